//--- branch_skip_compare_map.svh
`ifndef BRANCH_SKIP_COMPARE_MAP_SVH
`define BRANCH_SKIP_COMPARE_MAP_SVH

// ----------------------------------------------------------------------------
// flag word bit positions
// ----------------------------------------------------------------------------
`define FLAG_C_POS 0
`define FLAG_Z_POS 1
`define FLAG_N_POS 2
`define FLAG_V_POS 3
`define FLAG_S_POS 4
`define FLAG_H_POS 5
`define FLAG_T_POS 6
`define FLAG_I_POS 7

// ----------------------------------------------------------------------------
// cycle counts per outcome
// ----------------------------------------------------------------------------
`define CYC_SEQUENTIAL 3'h1
`define CYC_BRANCH_TAKEN 3'h2
`define CYC_SKIP_ONE_WORD 3'h2
`define CYC_SKIP_TWO_WORD 3'h3
`define CYC_CALL 3'h3
`define CYC_RETURN 3'h4

// ----------------------------------------------------------------------------
// program counter steps and reset values
// ----------------------------------------------------------------------------
`define PC_STEP_NEXT 16'h0001
`define PC_STEP_SKIP_ONE 16'h0002
`define PC_STEP_SKIP_TWO 16'h0003
`define PC_RESET 16'h0000
`define FLAGS_RESET 8'h00
`define CYC_RESET 3'h0

`endif

//--- branch_skip_compare_pkg.sv
package branch_skip_compare_pkg;

  typedef enum logic [4:0] {
    op_compare_regs = 5'h00,
    op_compare_with_borrow = 5'h01,
    op_compare_immediate = 5'h02,
    op_compare_skip_equal = 5'h03,
    op_skip_reg_bit_clear = 5'h04,
    op_skip_reg_bit_set = 5'h05,
    op_skip_io_bit_clear = 5'h06,
    op_skip_io_bit_set = 5'h07,
    op_branch_flag_set = 5'h08,
    op_branch_flag_clear = 5'h09,
    op_branch_zero_set = 5'h0a,
    op_branch_zero_clear = 5'h0b,
    op_branch_carry_set = 5'h0c,
    op_branch_carry_clear = 5'h0d,
    op_branch_unsigned_ge = 5'h0e,
    op_branch_unsigned_lt = 5'h0f,
    op_branch_negative = 5'h10,
    op_branch_positive = 5'h11,
    op_branch_signed_ge = 5'h12,
    op_branch_signed_less = 5'h13,
    op_branch_halfcarry_set = 5'h14,
    op_branch_halfcarry_clear = 5'h15,
    op_branch_transfer_set = 5'h16,
    op_branch_transfer_clear = 5'h17,
    op_branch_overflow_set = 5'h18,
    op_call_absolute = 5'h19,
    op_subroutine_exit = 5'h1a,
    op_interrupt_exit = 5'h1b
  } op_t;

  typedef enum logic [1:0] {
    st_idle = 2'b01,
    st_run = 2'b10
  } state_t;

endpackage : branch_skip_compare_pkg

//--- branch_skip_compare_unit.sv
// Behaviour
// - compare_skip_equal skips next instruction when operands equal; 1, 2 or 3 cycles.
// - skip_reg_bit_clear skips next instruction when selected register bit is zero.
// - skip_reg_bit_set skips next instruction when selected register bit is one.
// - skip_io_bit_clear skips when I/O bit b is zero; 1, 2 or 3 cycles.
// - skip_io_bit_set skips when I/O bit b is one; 1, 2 or 3 cycles.
// - branch_flag_set jumps to PC plus offset plus one when flag s is one.
// - branch_flag_clear jumps to PC plus offset plus one when flag s is zero.
// - carry clear/same-or-higher branch on carry zero; carry set/lower on carry one.
// - signed greater-or-equal branch taken only when N xor V is zero.
// - signed less-than branch taken only when N xor V is one.
// - half-carry-set branch jumps when H is one; 1 or 2 cycles.
// - half-carry-clear branch jumps when H is zero; 1 or 2 cycles.
// - transfer-set branch jumps when T is one, else falls through.
// - transfer-clear branch jumps when T is zero, else falls through.
// - overflow-set branch jumps when V is one; 1 or 2 cycles.
`timescale 1ns/1ns
`default_nettype none
`include "branch_skip_compare_map.svh"

module branch_skip_compare_unit
  import branch_skip_compare_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // instruction request
  input wire logic start,
  input wire op_t op,
  input wire logic [7:0] opa,
  input wire logic [7:0] opb,
  input wire logic [2:0] bit_sel,
  input wire logic [6:0] offset_k,
  input wire logic next_is_two_word,
  // machine state inputs
  input wire logic [15:0] pc_in,
  input wire logic [15:0] call_target,
  input wire logic [15:0] stack_pc,
  input wire logic [7:0] io_value,
  input wire logic [7:0] flags_in,
  // results
  output logic busy,
  output logic done,
  output logic [15:0] pc_out,
  output logic [7:0] flags_out,
  output logic flags_we,
  output logic gie_set
);

  // --------------------------------------------------------------------------
  // condition evaluation
  // --------------------------------------------------------------------------
  state_t state;
  logic [2:0] remaining;
  logic we_pending;
  logic gie_pending;
  logic take;
  logic [15:0] k_ext;
  logic [15:0] branch_target;
  logic [15:0] skip_target;
  logic [8:0] diff;
  logic [7:0] res;
  logic [7:0] cmp_flags;
  logic cond;
  logic [2:0] next_cycles;
  logic [15:0] next_pc;
  logic [7:0] next_flags;
  logic next_we;
  logic next_gie;

  assign take = start && (state == st_idle);
  assign k_ext = {{9{offset_k[6]}}, offset_k};
  assign branch_target = pc_in + k_ext + `PC_STEP_NEXT;
  assign skip_target = pc_in + (next_is_two_word ? `PC_STEP_SKIP_TWO : `PC_STEP_SKIP_ONE);

  // subtract without storing the difference
  always_comb begin
    diff = {1'b0, opa} - {1'b0, opb};
    if (op == op_compare_with_borrow) begin
      diff = diff - {8'h00, flags_in[`FLAG_C_POS]};
    end
    res = diff[7:0];
    cmp_flags = flags_in;
    cmp_flags[`FLAG_H_POS] = (~opa[3] & opb[3]) | (opb[3] & res[3]) | (res[3] & ~opa[3]);
    cmp_flags[`FLAG_V_POS] = (opa[7] & ~opb[7] & ~res[7]) | (~opa[7] & opb[7] & res[7]);
    cmp_flags[`FLAG_N_POS] = res[7];
    cmp_flags[`FLAG_S_POS] = res[7] ^ cmp_flags[`FLAG_V_POS];
    cmp_flags[`FLAG_C_POS] = (~opa[7] & opb[7]) | (opb[7] & res[7]) | (res[7] & ~opa[7]);
    if (op == op_compare_with_borrow) begin
      // zero stays set only if the whole multi-byte difference is zero
      cmp_flags[`FLAG_Z_POS] = (res == 8'h00) & flags_in[`FLAG_Z_POS];
    end else begin
      cmp_flags[`FLAG_Z_POS] = (res == 8'h00);
    end
  end

  always_comb begin
    cond = 1'b0;
    next_pc = pc_in + `PC_STEP_NEXT;
    next_cycles = `CYC_SEQUENTIAL;
    next_flags = flags_in;
    next_we = 1'b0;
    next_gie = 1'b0;
    unique case (op)
      op_compare_regs, op_compare_with_borrow, op_compare_immediate: begin
        next_flags = cmp_flags;
        next_we = 1'b1;
      end
      op_compare_skip_equal: cond = (opa == opb);
      op_skip_reg_bit_clear: cond = ~opa[bit_sel];
      op_skip_reg_bit_set: cond = opa[bit_sel];
      op_skip_io_bit_clear: cond = ~io_value[bit_sel];
      op_skip_io_bit_set: cond = io_value[bit_sel];
      op_branch_flag_set: cond = flags_in[bit_sel];
      op_branch_flag_clear: cond = ~flags_in[bit_sel];
      op_branch_zero_set: cond = flags_in[`FLAG_Z_POS];
      op_branch_zero_clear: cond = ~flags_in[`FLAG_Z_POS];
      op_branch_carry_set, op_branch_unsigned_lt: cond = flags_in[`FLAG_C_POS];
      op_branch_carry_clear, op_branch_unsigned_ge: cond = ~flags_in[`FLAG_C_POS];
      op_branch_negative: cond = flags_in[`FLAG_N_POS];
      op_branch_positive: cond = ~flags_in[`FLAG_N_POS];
      op_branch_signed_ge: cond = ~(flags_in[`FLAG_N_POS] ^ flags_in[`FLAG_V_POS]);
      op_branch_signed_less: cond = flags_in[`FLAG_N_POS] ^ flags_in[`FLAG_V_POS];
      op_branch_halfcarry_set: cond = flags_in[`FLAG_H_POS];
      op_branch_halfcarry_clear: cond = ~flags_in[`FLAG_H_POS];
      op_branch_transfer_set: cond = flags_in[`FLAG_T_POS];
      op_branch_transfer_clear: cond = ~flags_in[`FLAG_T_POS];
      op_branch_overflow_set: cond = flags_in[`FLAG_V_POS];
      op_call_absolute: begin
        next_pc = call_target;
        next_cycles = `CYC_CALL;
      end
      op_subroutine_exit: begin
        next_pc = stack_pc;
        next_cycles = `CYC_RETURN;
      end
      op_interrupt_exit: begin
        next_pc = stack_pc;
        next_cycles = `CYC_RETURN;
        next_flags[`FLAG_I_POS] = 1'b1;
        next_we = 1'b1;
        next_gie = 1'b1;
      end
      // unused codes retire as a one-cycle no-op
      default: cond = 1'b0;
    endcase
    if (cond && (op >= op_compare_skip_equal) && (op <= op_skip_io_bit_set)) begin
      next_pc = skip_target;
      next_cycles = next_is_two_word ? `CYC_SKIP_TWO_WORD : `CYC_SKIP_ONE_WORD;
    end
    if (cond && (op >= op_branch_flag_set) && (op <= op_branch_overflow_set)) begin
      next_pc = branch_target;
      next_cycles = `CYC_BRANCH_TAKEN;
    end
  end

  // --------------------------------------------------------------------------
  // cycle sequencing
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= st_idle;
      remaining <= `CYC_RESET;
    end else begin
      unique case (state)
        st_idle: begin
          if (take) begin
            state <= st_run;
            remaining <= next_cycles;
          end
        end
        st_run: begin
          remaining <= remaining - 3'h1;
          if (remaining == 3'h1) begin
            state <= st_idle;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pc_out <= `PC_RESET;
      flags_out <= `FLAGS_RESET;
      we_pending <= 1'b0;
      gie_pending <= 1'b0;
    end else if (take) begin
      pc_out <= next_pc;
      flags_out <= next_flags;
      we_pending <= next_we;
      gie_pending <= next_gie;
    end
  end

  assign busy = (state == st_run);
  assign done = (state == st_run) && (remaining == 3'h1);
  assign flags_we = done && we_pending;
  assign gie_set = done && gie_pending;

  // --------------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  AST_COMPARE_ONE_CYCLE: assert property (
    take && (op == op_compare_regs || op == op_compare_immediate) |=>
      done && flags_we && pc_out == $past(pc_in) + 16'h0001)
    else $error("compare did not retire in one cycle");
  AST_COMPARE_EQUAL_FLAGS: assert property (
    take && op == op_compare_regs && opa == opb |=>
      flags_out[`FLAG_Z_POS] && !flags_out[`FLAG_C_POS] && !flags_out[`FLAG_N_POS])
    else $error("compare of equal values gave wrong flags");
  AST_CSE_SKIP: assert property (
    take && op == op_compare_skip_equal && opa == opb && !next_is_two_word |->
      ##1 !done ##1 done && pc_out == $past(pc_in, 2) + 16'h0002)
    else $error("equal compare did not skip one word");
  AST_CSE_NO_SKIP: assert property (
    take && op == op_compare_skip_equal && opa != opb |=>
      done && pc_out == $past(pc_in) + 16'h0001)
    else $error("unequal compare skipped");
  AST_REG_CLEAR_TWO_WORD: assert property (
    take && op == op_skip_reg_bit_clear && !opa[bit_sel] && next_is_two_word |=>
      !done [*2] ##1 done && pc_out == $past(pc_in, 3) + 16'h0003)
    else $error("register bit clear skip over two words wrong");
  AST_REG_SET_SKIP: assert property (
    take && op == op_skip_reg_bit_set && opa[bit_sel] && !next_is_two_word |->
      ##2 done && pc_out == $past(pc_in, 2) + 16'h0002)
    else $error("register bit set skip wrong");
  AST_IO_CLEAR_NO_SKIP: assert property (
    take && op == op_skip_io_bit_clear && io_value[bit_sel] |=>
      done && pc_out == $past(pc_in) + 16'h0001)
    else $error("io bit clear skipped on a set bit");
  AST_IO_SET_SKIP: assert property (
    take && op == op_skip_io_bit_set && io_value[bit_sel] && !next_is_two_word |->
      ##2 done && pc_out == $past(pc_in, 2) + 16'h0002)
    else $error("io bit set skip wrong");
  AST_FLAG_SET_TAKEN: assert property (
    take && op == op_branch_flag_set && flags_in[bit_sel] |->
      ##2 done && pc_out == $past(pc_in, 2) + $past(k_ext, 2) + 16'h0001)
    else $error("taken flag branch wrong target or timing");
  AST_FLAG_CLEAR_NOT_TAKEN: assert property (
    take && op == op_branch_flag_clear && flags_in[bit_sel] |=>
      done && pc_out == $past(pc_in) + 16'h0001)
    else $error("flag clear branch taken on set flag");
  AST_CARRY_CLEAR: assert property (
    take && op == op_branch_unsigned_ge && !flags_in[`FLAG_C_POS] |->
      ##2 done && pc_out == $past(pc_in, 2) + $past(k_ext, 2) + 16'h0001)
    else $error("same-or-higher branch not taken on carry clear");
  AST_SIGNED_GE_NOT_TAKEN: assert property (
    take && op == op_branch_signed_ge && (flags_in[`FLAG_N_POS] ^ flags_in[`FLAG_V_POS]) |=>
      done && pc_out == $past(pc_in) + 16'h0001)
    else $error("signed ge branch taken with N xor V set");
  AST_SIGNED_LESS_TAKEN: assert property (
    take && op == op_branch_signed_less && (flags_in[`FLAG_N_POS] ^ flags_in[`FLAG_V_POS]) |->
      ##1 !done ##1 done && pc_out == $past(pc_in, 2) + $past(k_ext, 2) + 16'h0001)
    else $error("signed less branch not taken in two cycles");
  AST_CALL_TIMING: assert property (
    take && op == op_call_absolute |->
      ##3 done && pc_out == $past(call_target, 3))
    else $error("call did not load target in three cycles");
  AST_INT_EXIT: assert property (
    take && op == op_interrupt_exit |->
      ##4 done && gie_set && flags_out[`FLAG_I_POS] && pc_out == $past(stack_pc, 4))
    else $error("interrupt exit timing or flag wrong");

  COV_SKIP_TWO_WORD: cover property (
    take && op == op_compare_skip_equal && opa == opb && next_is_two_word ##3 done);
  COV_BRANCH_TAKEN: cover property (
    take && op == op_branch_zero_set && flags_in[`FLAG_Z_POS] ##2 done);
  COV_COMPARE_BORROW: cover property (take && op == op_compare_with_borrow ##1 flags_we);
  COV_INT_EXIT: cover property (gie_set);

endmodule : branch_skip_compare_unit
`default_nettype wire

//--- fetch_pc_model.sv
`timescale 1ns/1ns
`default_nettype none

module fetch_pc_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // unit results
  input wire logic done,
  input wire logic [15:0] pc_out,
  // bench preset
  input wire logic preset,
  input wire logic [15:0] preset_pc,
  // fetch address
  output logic [15:0] pc_in
);
  // --------------------------------------------------------------------------
  // program counter follows each finished instruction
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pc_in <= 16'h0000;
    end else if (preset) begin
      pc_in <= preset_pc;
    end else if (done) begin
      pc_in <= pc_out;
    end
  end
endmodule : fetch_pc_model

`default_nettype wire

//--- branch_skip_compare_unit_test.sv
`timescale 1ns/1ns
`default_nettype none

module branch_skip_compare_unit_test;
  import branch_skip_compare_pkg::*;
  logic clk_sys = 1'b0, rst_n = 1'b0, start = 1'b0, next_is_two_word = 1'b0, preset = 1'b0;
  op_t op = op_compare_regs;
  logic [7:0] opa = 8'h00, opb = 8'h00, io_value = 8'h00, flags_in = 8'h00, flags_out;
  logic [2:0] bit_sel = 3'h0;
  logic [6:0] offset_k = 7'h00;
  logic [15:0] call_target = 16'h0000, stack_pc = 16'h0000, preset_pc = 16'h0000;
  logic [15:0] pc_in, pc_out;
  logic busy, done, flags_we, gie_set;
  logic [31:0] r, r2, seed;
  int err_total = 0, samples_checked = 0;

  always #5 clk_sys = ~clk_sys;

  branch_skip_compare_unit branch_skip_compare_unit_i (.clk_sys(clk_sys), .rst_n(rst_n),
    .start(start), .op(op), .opa(opa), .opb(opb), .bit_sel(bit_sel), .offset_k(offset_k),
    .next_is_two_word(next_is_two_word), .pc_in(pc_in), .call_target(call_target),
    .stack_pc(stack_pc), .io_value(io_value), .flags_in(flags_in), .busy(busy), .done(done),
    .pc_out(pc_out), .flags_out(flags_out), .flags_we(flags_we), .gie_set(gie_set));

  fetch_pc_model fetch_pc_model_i (.clk_sys(clk_sys), .rst_n(rst_n), .done(done),
    .pc_out(pc_out), .preset(preset), .preset_pc(preset_pc), .pc_in(pc_in));

  // --------------------------------------------------------------------------
  // expectations
  // --------------------------------------------------------------------------
  function automatic logic cond_of(input op_t o, input logic [7:0] a, b, input logic [2:0] s,
      input logic [7:0] io, f);
    case (o)
      op_compare_skip_equal: return a == b;
      op_skip_reg_bit_clear: return !a[s];
      op_skip_reg_bit_set: return a[s];
      op_skip_io_bit_clear: return !io[s];
      op_skip_io_bit_set: return io[s];
      op_branch_flag_set: return f[s];
      op_branch_flag_clear: return !f[s];
      op_branch_zero_set: return f[1];
      op_branch_zero_clear: return !f[1];
      op_branch_carry_set, op_branch_unsigned_lt: return f[0];
      op_branch_carry_clear, op_branch_unsigned_ge: return !f[0];
      op_branch_negative: return f[2];
      op_branch_positive: return !f[2];
      op_branch_signed_ge: return !(f[2] ^ f[3]);
      op_branch_signed_less: return f[2] ^ f[3];
      op_branch_halfcarry_set: return f[5];
      op_branch_halfcarry_clear: return !f[5];
      op_branch_transfer_set: return f[6];
      op_branch_transfer_clear: return !f[6];
      op_branch_overflow_set: return f[3];
      default: return 1'b0;
    endcase
  endfunction : cond_of

  function automatic logic [7:0] cmp_flags(input op_t o, input logic [7:0] a, b, f);
    logic [7:0] res;
    logic [7:0] n;
    logic wb;
    wb = (o == op_compare_with_borrow);
    res = a - b - {7'h00, wb & f[0]};
    n = f;
    n[0] = (!a[7] & b[7]) | (b[7] & res[7]) | (res[7] & !a[7]);
    n[1] = (res == 8'h00) & (!wb | f[1]);
    n[2] = res[7];
    n[3] = (a[7] & !b[7] & !res[7]) | (!a[7] & b[7] & res[7]);
    n[4] = n[2] ^ n[3];
    n[5] = (!a[3] & b[3]) | (b[3] & res[3]) | (res[3] & !a[3]);
    return n;
  endfunction : cmp_flags

  // --------------------------------------------------------------------------
  // checking and closing
  // --------------------------------------------------------------------------
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : wrap_up

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : check

  // one instruction; poke raises start while busy, which must be ignored
  task automatic run_op(input op_t o, input logic [7:0] a, b, input logic [2:0] s,
      input logic [6:0] k, input logic two, input logic [7:0] f, io, input logic setpc,
      input logic [15:0] p, input logic poke);
    logic [15:0] epc;
    logic [7:0] ef;
    logic is_cmp, c;
    int n, en;
    if (setpc) begin
      preset = 1'b1;
      preset_pc = p;
      @(posedge clk_sys);
      #1;
      preset = 1'b0;
    end
    call_target = 16'($urandom);
    stack_pc = 16'($urandom);
    is_cmp = o inside {op_compare_regs, op_compare_with_borrow, op_compare_immediate};
    c = cond_of(o, a, b, s, io, f);
    en = 1;
    epc = pc_in + 16'h0001;
    ef = f;
    if (is_cmp) begin
      ef = cmp_flags(o, a, b, f);
    end else if (o inside {[op_compare_skip_equal:op_skip_io_bit_set]}) begin
      en = c ? (two ? 3 : 2) : 1;
      epc = pc_in + (c ? (two ? 16'h0003 : 16'h0002) : 16'h0001);
    end else if (o == op_call_absolute) begin
      en = 3;
      epc = call_target;
    end else if (o inside {op_subroutine_exit, op_interrupt_exit}) begin
      en = 4;
      epc = stack_pc;
      ef[7] = ef[7] | (o == op_interrupt_exit);
    end else if (c) begin
      en = 2;
      epc = pc_in + {{9{k[6]}}, k} + 16'h0001;
    end
    op = o;
    opa = a;
    opb = b;
    bit_sel = s;
    offset_k = k;
    next_is_two_word = two;
    flags_in = f;
    io_value = io;
    start = 1'b1;
    @(posedge clk_sys);
    #1;
    start = poke;
    op = op_call_absolute;
    check(16'(busy), 16'h0001);
    n = 1;
    while (done !== 1'b1 && n < 8) begin
      @(posedge clk_sys);
      #1;
      start = 1'b0;
      n++;
    end
    check(16'(n), 16'(en));
    if (done !== 1'b1) wrap_up();
    check(pc_out, epc);
    check(16'(flags_out), 16'(ef));
    check(16'(flags_we), 16'(is_cmp | (o == op_interrupt_exit)));
    check(16'(gie_set), 16'(o == op_interrupt_exit));
    @(posedge clk_sys);
    #1;
    start = 1'b0;
    check(16'({busy, done}), 16'h0000);
  endtask : run_op

  // --------------------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------------------
  initial begin
    seed = $urandom(32'h0297);
    repeat (12) @(posedge clk_sys);
    check(pc_out, 16'h0000);
    check(16'({busy, done, flags_we, gie_set, flags_out}), 16'h0000);
    #1;
    rst_n = 1'b1;
    run_op(op_compare_skip_equal, 8'h5a, 8'h5a, 3'h0, 7'h00, 1'b1, 8'h00, 8'h00, 1'b1, 16'hfffe, 1'b0);
    run_op(op_branch_zero_set, 8'h00, 8'h00, 3'h0, 7'h40, 1'b0, 8'h02, 8'h00, 1'b1, 16'h0010, 1'b0);
    run_op(op_branch_signed_ge, 8'h00, 8'h00, 3'h0, 7'h3f, 1'b0, 8'h0c, 8'h00, 1'b0, 16'h0000, 1'b0);
    run_op(op_compare_with_borrow, 8'h33, 8'h33, 3'h0, 7'h00, 1'b0, 8'h03, 8'h00, 1'b0, 16'h0000, 1'b0);
    run_op(op_interrupt_exit, 8'h00, 8'h00, 3'h0, 7'h00, 1'b0, 8'h41, 8'h00, 1'b0, 16'h0000, 1'b1);
    // reset in the middle of a call must drop everything at once
    op = op_call_absolute;
    start = 1'b1;
    @(posedge clk_sys);
    #1;
    start = 1'b0;
    rst_n = 1'b0;
    #1;
    check(pc_out, 16'h0000);
    check(16'({busy, done, flags_we, gie_set, flags_out}), 16'h0000);
    @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    @(posedge clk_sys);
    #1;
    check(16'({busy, done, flags_we, gie_set, flags_out}), 16'h0000);
    for (int i = 0; i < 32; i++) begin
      for (int j = 0; j < 8; j++) begin
        r = $urandom;
        r2 = $urandom;
        run_op(op_t'(i[4:0]), r[7:0], j[0] ? r[7:0] : r[15:8], r[18:16], r[25:19], r[26],
          r2[7:0], r2[15:8], r2[16], r2[31:16], 1'b0);
      end
    end
    wrap_up();
  end
endmodule : branch_skip_compare_unit_test

`default_nettype wire
